/* core/acs_scheduler.sv */
// conversion scheduler and control register of the secondary converter
`timescale 1ns/10ps
`include "acs_map.svh"
module acs_scheduler (
   input  wire logic       clk,               // system clock, 100 MHz
   input  wire logic       nrst,              // async reset, active low
   input  wire logic       ce,                // clock enable, freezes all state
   input  wire logic [7:0] sfr_addr,          // register address
   input  wire logic [7:0] sfr_wdata,         // write data
   input  wire logic       sfr_wr,            // write strobe
   input  wire logic       sfr_rd,            // read strobe
   output logic      [7:0] sfr_rdata,         // read data, registered
   input  wire logic       conv_clk_tick,     // converter clock pulse
   input  wire logic       t3_ovf,            // timer 3 overflow pulse
   input  wire logic       t2_ovf,            // timer 2 overflow pulse
   input  wire logic       primary_start,     // primary busy write of 1
   input  wire logic       convert_start_pin, // external start level
   input  wire logic [7:0] core_result,       // sampled result from core
   output logic            core_power,        // converter powered
   output logic            core_track,        // sampler tracking
   output logic            core_convert,      // conversion running
   output logic [7:0]      result,            // latched result
   output logic            done_irq           // completion flag level
);
   acs_pkg::acs_state_e state;
   acs_pkg::acs_state_e next_state;
   logic       en;
   logic       tm;
   logic       done;
   acs_pkg::acs_mode_t mode;
   logic [1:0] trk_cnt;
   logic [3:0] cnv_cnt;
   logic       trig;
   logic       pin_low;

   // --------------------------------------------------------------
   // bus decode
   // --------------------------------------------------------------
   // only the one control address answers; any other address reads 0
   wire       ctrl_sel  = (sfr_addr == `ACS_CTRL_ADDR);
   wire       ctrl_wr   = ctrl_sel & sfr_wr;
   wire       ctrl_rd   = ctrl_sel & sfr_rd;
   // a 0 write to the busy bit does nothing
   wire       sw_start  = ctrl_wr & sfr_wdata[`ACS_BIT_BUSY];
   wire       wr_en     = sfr_wdata[`ACS_BIT_EN];
   wire       wr_tm     = sfr_wdata[`ACS_BIT_TM];
   wire       wr_done   = sfr_wdata[`ACS_BIT_DONE];
   wire [2:0] wr_mode   = sfr_wdata[`ACS_CM_HI:`ACS_CM_LO];
   wire       pin_mode  = (mode == 3'h2);
   wire       busy      = (state == acs_pkg::ACS_CONV);
   wire [7:0] ctrl_view = {en, tm, done, busy, mode, 1'b0};

   // --------------------------------------------------------------
   // converter-clock counting
   // --------------------------------------------------------------
   // counts advance only on converter clocks
   wire       trk_done     = (trk_cnt == `ACS_TRACK_CLKS);
   wire       cnv_done     = conv_clk_tick & (cnv_cnt == `ACS_CONV_CLKS - 4'h1);
   wire       finish       = busy & cnv_done;                // busy falling edge
   wire [1:0] next_trk_cnt = (state != acs_pkg::ACS_TRACK) ? 2'h0 :
                             (conv_clk_tick ? trk_cnt + 2'h1 : trk_cnt);
   wire [3:0] next_cnv_cnt = (state != acs_pkg::ACS_CONV) ? 4'h0 :
                             (conv_clk_tick ? cnv_cnt + 4'h1 : cnv_cnt);
   // set beats a software clear landing in the same cycle
   wire       next_done    = finish | (ctrl_wr ? wr_done : done);

   acs_trigger_sel u_trig (
      .clk               (clk),
      .nrst              (nrst),
      .ce                (ce),
      .mode              (mode),
      .sw_start          (sw_start),
      .t3_ovf            (t3_ovf),
      .t2_ovf            (t2_ovf),
      .primary_start     (primary_start),
      .convert_start_pin (convert_start_pin),
      .trig              (trig),
      .pin_low           (pin_low)
   );

   // --------------------------------------------------------------
   // next-state logic
   // --------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         acs_pkg::ACS_OFF: begin
            if (en) begin
               next_state = acs_pkg::ACS_IDLE;
            end
         end
         acs_pkg::ACS_IDLE: begin
            if (!en) begin
               next_state = acs_pkg::ACS_OFF;
            end else if (trig) begin
               // low-power timed modes track first; pin mode already tracked
               if (tm && (mode != 3'h2)) begin
                  next_state = acs_pkg::ACS_TRACK;
               end else begin
                  next_state = acs_pkg::ACS_CONV;
               end
            end
         end
         acs_pkg::ACS_TRACK: begin
            if (!en) begin
               next_state = acs_pkg::ACS_OFF;
            end else if (trk_done) begin
               next_state = acs_pkg::ACS_CONV;
            end
         end
         acs_pkg::ACS_CONV: begin
            if (!en) begin
               next_state = acs_pkg::ACS_OFF;
            end else if (cnv_done) begin
               next_state = acs_pkg::ACS_IDLE;
            end
         end
         default: next_state = acs_pkg::ACS_OFF;
      endcase
   end

   // --------------------------------------------------------------
   // output decode
   // --------------------------------------------------------------
   // outputs follow next_state so they change with the state flop
   wire       next_power   = (next_state != acs_pkg::ACS_OFF);
   // normal mode tracks whenever idle; pin mode only while pin low
   wire       idle_track   = ~tm | (pin_mode & pin_low);
   wire       next_track   = (next_state == acs_pkg::ACS_TRACK) |
                             ((next_state == acs_pkg::ACS_IDLE) & idle_track);
   wire       next_convert = (next_state == acs_pkg::ACS_CONV);
   wire [7:0] next_rdata   = ctrl_rd ? ctrl_view : 8'h00;

   // --------------------------------------------------------------
   // state and converter-clock counters
   // --------------------------------------------------------------
   // state flop; shutdown is the safe state out of reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= acs_pkg::ACS_OFF;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // tracking length in converter clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trk_cnt <= 2'h0;
      end else if (ce) begin
         trk_cnt <= next_trk_cnt;
      end
   end

   // conversion length in converter clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnv_cnt <= 4'h0;
      end else if (ce) begin
         cnv_cnt <= next_cnv_cnt;
      end
   end

   // --------------------------------------------------------------
   // control register
   // --------------------------------------------------------------
   // configuration fields; a write while ce is low is lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         en   <= 1'b0;
         tm   <= 1'b0;
         mode <= 3'h0;
      end else if (ce && ctrl_wr) begin
         en   <= wr_en;
         tm   <= wr_tm;
         mode <= wr_mode;
      end
   end

   // completion flag; hardware set beats software clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
      end else if (ce) begin
         done <= next_done;
      end
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   // read data stands for one cycle after the read strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
      end else if (ce) begin
         sfr_rdata <= next_rdata;
      end
   end

   // result holds until the next conversion ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result <= 8'h00;
      end else if (ce && finish) begin
         result <= core_result;
      end
   end

   // converter controls; the flag output mirrors the flag itself
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_power   <= 1'b0;
         core_track   <= 1'b0;
         core_convert <= 1'b0;
         done_irq     <= 1'b0;
      end else if (ce) begin
         core_power   <= next_power;
         core_track   <= next_track;
         core_convert <= next_convert;
         done_irq     <= next_done;
      end
   end
endmodule

/* shared/acs_map.svh */
// register offset, field positions, reset value and timing counts of the scheduler
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_CTRL_ADDR    8'haa
`define ACS_CTRL_RESET   8'h00
`define ACS_BIT_EN       7
`define ACS_BIT_TM       6
`define ACS_BIT_DONE     5
`define ACS_BIT_BUSY     4
`define ACS_CM_HI        3
`define ACS_CM_LO        1
`define ACS_TRACK_CLKS   2'h3
`define ACS_CONV_CLKS    4'h8
`endif

/* shared/acs_pkg.sv */
// types shared by the converter scheduler
package acs_pkg;
   typedef enum logic [3:0] {
      ACS_IDLE  = 4'h1,
      ACS_TRACK = 4'h2,
      ACS_CONV  = 4'h4,
      ACS_OFF   = 4'h8
   } acs_state_e;
   typedef logic [2:0] acs_mode_t;
endpackage

/* core/acs_trigger_sel.sv */
// start-trigger selection for the converter scheduler
`timescale 1ns/10ps
module acs_trigger_sel (
   input  wire logic               clk,               // system clock
   input  wire logic               nrst,              // async reset, active low
   input  wire logic               ce,                // clock enable
   input  wire acs_pkg::acs_mode_t mode,              // start-mode field
   input  wire logic               sw_start,          // software busy write of 1
   input  wire logic               t3_ovf,            // timer 3 overflow pulse
   input  wire logic               t2_ovf,            // timer 2 overflow pulse
   input  wire logic               primary_start,     // primary busy write of 1
   input  wire logic               convert_start_pin, // external start level
   output logic                    trig,              // selected start pulse
   output logic                    pin_low            // start pin currently low
);
   logic pin_q;
   logic pin_rise;

   // --------------------------------------------------------------
   // edge detect on the start pin
   // --------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_q <= 1'b1;  // high at reset so no false edge
      end else if (ce) begin
         pin_q <= convert_start_pin;
      end
   end
   assign pin_rise = convert_start_pin & ~pin_q;
   assign pin_low  = ~convert_start_pin;

   // mode decode of the trigger source
   assign trig = mode[2]          ? primary_start :
                 (mode == 3'h0)   ? sw_start :
                 (mode == 3'h1)   ? t3_ovf :
                 (mode == 3'h2)   ? pin_rise : t2_ovf;
endmodule

/* verif/acs_conv_model.sv */
// converter core stand-in: produces the converter clock ticks
`timescale 1ns/10ps
module acs_conv_model (
   input  wire logic clk,           // system clock
   input  wire logic nrst,          // async reset, active low
   input  wire logic core_power,    // converter powered
   output logic      conv_clk_tick  // one pulse per converter clock
);
   logic [1:0] div;
   // tick every fourth cycle; held still while unpowered so no stray ticks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) div <= 2'h0;
      else div <= core_power ? div + 2'h1 : 2'h0;
   end
   assign conv_clk_tick = core_power && (div == 2'h3);
endmodule

/* verif/acs_scheduler_assertions.sv */
// port-level checks of the converter scheduler
`timescale 1ns/10ps
module acs_scheduler_checker (
   input wire logic       clk,          // system clock
   input wire logic       nrst,         // async reset
   input wire logic       ce,           // clock enable
   input wire logic [7:0] sfr_addr,     // register address
   input wire logic [7:0] sfr_wdata,    // write data
   input wire logic       sfr_wr,       // write strobe
   input wire logic [7:0] core_result,  // core result
   input wire logic       core_power,   // powered
   input wire logic       core_track,   // tracking
   input wire logic       core_convert, // converting
   input wire logic [7:0] result,       // latched result
   input wire logic       done_irq      // completion flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // control writes decoded once for the write-related checks
   wire wr_ctl = ce && sfr_wr && sfr_addr == 8'haa;
   wire clr = wr_ctl && !sfr_wdata[5];
   AST_TRACK_EXCL: assert property (!(core_track && core_convert))
      else $error("track in conversion");
   AST_DONE_SET: assert property ($fell(core_convert) && core_power |-> ##[0:3] done_irq)
      else $error("no done");
   AST_OFF_IDLE: assert property (!core_power |-> !core_convert)
      else $error("converting off");
   AST_CONV_HOLD: assert property ($rose(core_convert) |-> core_convert[*8])
      else $error("short conv");
   AST_RESULT: assert property ($fell(core_convert) |-> ##[0:3] result == core_result)
      else $error("result not latched");
   AST_EN_ON: assert property (wr_ctl && sfr_wdata[7] |-> ##[1:2] core_power)
      else $error("no power");
   AST_EN_OFF: assert property (wr_ctl && !sfr_wdata[7] |-> ##[1:2] !core_power)
      else $error("still powered");
   AST_STICKY: assert property ($fell(done_irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
      else $error("done lost without clear");
endmodule
bind acs_scheduler acs_scheduler_checker u_chk (.clk(clk), .nrst(nrst), .ce(ce),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .core_result(core_result),
   .core_power(core_power), .core_track(core_track), .core_convert(core_convert),
   .result(result), .done_irq(done_irq));

/* verif/acs_scheduler_bench.sv */
// self-checking bench of the converter scheduler
`timescale 1ns/10ps
module acs_scheduler_bench;
   logic       clk = 1'b0, nrst = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic       pin = 1'b1, pd = 1'b0, tick, pw, trk, cnv, done;
   logic [2:0] sel = 3'h0;
   logic [7:0] addr = 8'h00, wd = 8'h00, res = 8'h00, rd, rs, n;
   logic [7:0] q[$];
   int         fails = 0, check_count = 0;
   always #5 clk = ~clk;
   acs_conv_model u_core (.clk(clk), .nrst(nrst), .core_power(pw), .conv_clk_tick(tick));
   acs_scheduler dut (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(addr), .sfr_wdata(wd),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rd), .conv_clk_tick(tick), .t3_ovf(sel[0]),
      .t2_ovf(sel[1]), .primary_start(sel[2]), .convert_start_pin(pin), .core_result(res),
      .core_power(pw), .core_track(trk), .core_convert(cnv), .result(rs), .done_irq(done));
   task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 cmp("rdata", exp, rd);
   endtask
   // bounded wait, also hands back the cycles it took
   task automatic wait_hi(const ref logic s, output logic [7:0] k);
      k = 8'h00;
      while (s !== 1'b1 && k < 8'hc0) begin
         @(posedge clk);
         k++;
      end
   endtask
   // one conversion in the given track mode and start mode
   task automatic run(input logic tm, input logic [2:0] m);
      logic [7:0] c, v;
      c = {1'b1, tm, 2'b00, m, 1'b0};
      v = 8'($urandom);
      wr(8'haa, c);
      repeat (2) @(posedge clk);
      #1 cmp("idle_track", {7'h00, ~tm}, {7'h00, trk});
      q.push_back(v);
      @(posedge clk);
      res <= v;
      addr <= 8'haa;
      wd <= c | 8'h10;
      sfr_wr <= (m == 3'h0);
      sel <= (m == 3'h1) ? 3'h1 : (m == 3'h3) ? 3'h2 : m[2] ? 3'h4 : 3'h0;
      pin <= (m != 3'h2);
      @(posedge clk);
      sfr_wr <= 1'b0;
      sel <= 3'h0;
      if (m == 3'h2) begin
         repeat (3) @(posedge clk);
         #1 cmp("pin_track", 8'h01, {7'h00, trk});
         @(posedge clk);
         pin <= 1'b1;
         @(posedge clk);
      end
      wait_hi(cnv, n);
      cmp("slow_start", {7'h00, tm && m != 3'h2}, {7'h00, n > 8'h05});
      wait_hi(done, n);
      cmp("done_seen", 8'h01, {7'h00, done});
      rdchk(8'haa, c | 8'h20);
      wr(8'haa, c);
      repeat (3) @(posedge clk);
      #1 cmp("done_clear", 8'h00, {7'h00, done});
      $display("test tm=%0d mode=%0d ended", tm, m);
   endtask
   // result watcher: each new completion takes the oldest expected word
   always @(posedge clk) begin
      pd <= done;
      if (done === 1'b1 && pd !== 1'b1) cmp("result", q.size() ? q.pop_front() : 8'hxx, rs);
   end
   initial begin
      void'($urandom(46883));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rdchk(8'haa, 8'h00);
      rdchk(8'h55, 8'h00);
      wr(8'haa, 8'h10);
      wait_hi(cnv, n);
      cmp("off_conv", 8'hc0, n);
      for (int i = 0; i < 16; i++) run(i[3], i[2:0]);
      // an unmapped write must leave the converter powered
      wr(8'h55, 8'h00);
      repeat (2) @(posedge clk);
      #1 cmp("power_kept", 8'h01, {7'h00, pw});
      rdchk(8'h55, 8'h00);
      // a write while the clock enable is low must be lost
      ce <= 1'b0;
      wr(8'haa, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      rdchk(8'haa, 8'hce);
      $display("test register map ended");
      conclude();
   end
   // watchdog: sixteen runs of under a hundred cycles each fit well inside this
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule
